/* core/ep_dma_engine.sv */
// one endpoint's data request flag and automatic dma packet counter
// assumes the dma controller moves two bytes per access of the word port
`timescale 1ns/10ps
`default_nettype none
module ep_dma_engine #(
  parameter int PKS_W = usbh_pkg::PKS_W,
  parameter int BLK_W = usbh_pkg::BLK_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             auto_en,
  input  wire logic             req_en,
  input  wire logic [PKS_W-1:0] pkt_size,
  input  wire logic [BLK_W-1:0] blk_count,
  input  wire logic             blk_load,
  input  wire logic             flag_set,
  input  wire logic             flag_clear,
  input  wire logic             word_access,
  output logic                  flag,
  output logic                  dma_req,
  output logic                  done,
  output logic      [BLK_W-1:0] remaining
);

  logic [PKS_W:0] pkt_cnt_reg;
  logic [PKS_W:0] pkt_cnt_next;
  logic           moving;
  logic           auto_clear;

  // elaboration guard: the packet and byte counters need at least two bits
  if (PKS_W < 2 || BLK_W < 2) begin : g_bad_width
    $error("ep_dma_engine: widths too small");
  end

  // only two-byte moves count, so odd tails stay with software
  assign moving       = word_access & flag & auto_en;
  assign pkt_cnt_next = pkt_cnt_reg + (PKS_W+1)'(2);
  assign auto_clear   = moving & (pkt_cnt_next >= {1'b0, pkt_size});

  // request line held only while flag and both enables stand
  assign dma_req = flag & auto_en & req_en & ~done;

  // bytes moved within the current packet
  always_ff @(posedge clk) begin
    if (rst) begin
      pkt_cnt_reg <= '0;
    end else if (auto_clear || blk_load || !auto_en) begin
      pkt_cnt_reg <= '0;
    end else if (moving) begin
      pkt_cnt_reg <= pkt_cnt_next;
    end
  end

  // request flag: a new packet completion wins over any clear
  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (flag_set) begin
      flag <= 1'b1;
    end else if (flag_clear || auto_clear) begin
      flag <= 1'b0;
    end
  end

  // total byte budget; zero means no budget programmed
  always_ff @(posedge clk) begin
    if (rst) begin
      remaining <= '0;
      done      <= 1'b0;
    end else if (blk_load) begin
      remaining <= blk_count;
      done      <= 1'b0;
    end else if (moving && remaining != '0) begin
      remaining <= (remaining > BLK_W'(2)) ? remaining - BLK_W'(2) : '0;
      done      <= (remaining <= BLK_W'(2));
    end
  end

endmodule
`default_nettype wire

/* core/pin_sync.sv */
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes inputs change far slower than the clock
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          level[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

/* core/usb_host_autodma_top.sv */
// usb host auto-dma, suspend/resume and detach detection with apb registers
// assumes a zero-wait apb master, the token engine reporting packet ends,
// and an external endpoint buffer that answers while psel is high
//
// Operation
// - an endpoint runs automatic dma only while its auto-dma enable is set
// - the request flag clears itself after one packet size of bytes moved
// - requests repeat packet after packet until the total byte count is reached
// - automatic moves count two bytes; an odd last byte needs software
// - setting suspend floats the bus and stops clocks not needed
// - resume on suspend cleared, k-state, disconnect or connect
// - both lines low for 2.5 us or longer means the device detached
// - detach clears connection state, sets the disconnect flag, may interrupt
// - the disconnect flag clears by writing one to it
// - bus reset clears connection state without setting the disconnect flag
// - each endpoint has byte and word data ports, control, status, block
// - high, medium and low cause registers for host and endpoint events
// - set, mask and masked companions for both interrupt registers
// - two level selection registers place each source on a priority level
// - a normal packet end sets the endpoint request flag, maskable interrupt
`timescale 1ns/10ps
`default_nettype none
module usb_host_autodma_top #(
  parameter int DISC_CYCLES = usbh_pkg::DISC_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dp_in,
  input  wire logic        dm_in,
  input  wire logic        low_speed,
  input  wire logic        tx_dp,
  input  wire logic        tx_dm,
  input  wire logic        tx_oe,
  output logic             dp_out,
  output logic             dm_out,
  output logic             usb_oe,
  output logic             clk_run_en,
  input  wire logic        bus_reset_active,
  input  wire logic [1:0]  pkt_done,
  output logic      [1:0]  dma_req,
  output logic      [1:0]  buf_wr,
  output logic      [1:0]  buf_rd,
  output logic             buf_two_byte,
  output logic      [15:0] buf_wdata,
  input  wire logic [15:0] buf_rdata0,
  input  wire logic [15:0] buf_rdata1,
  output logic             irq_hi,
  output logic             irq_med,
  output logic             irq_lo
);

  localparam int NEP = usbh_pkg::NUM_EP;
  localparam int HN  = usbh_pkg::HOST_SRC_N;
  localparam int EN  = usbh_pkg::EP_SRC_N;
  localparam int CW  = usbh_pkg::DISC_CNT_W;
  localparam int PW  = usbh_pkg::PKS_W;
  localparam int BW  = usbh_pkg::BLK_W;

  // elaboration guard: the line timer must reach its terminal count
  if (DISC_CYCLES < 2 || DISC_CYCLES >= (1 << CW)) begin : g_bad_disc
    $error("usb_host_autodma_top: DISC_CYCLES out of range");
  end

  usbh_pkg::bus_state_e state_reg;

  logic          suspend_request_req_reg;
  logic          conn_reg;
  logic [HN-1:0] host_flag_reg;
  logic [HN-1:0] host_mask_reg;
  logic [EN-1:0] ep_mask_reg;
  logic [2*HN-1:0] lvl1_reg;
  logic [2*EN-1:0] lvl2_reg;
  logic [1:0]    drq_en_reg;
  logic [PW-1:0] pks_reg  [NEP];
  logic [1:0]    auto_reg;
  logic [BW-1:0] blk_reg  [NEP];
  logic [CW-1:0] line_cnt_reg;
  logic [31:0]   rd_data;
  logic          hit;
  logic          setup;
  logic          wr_acc;
  logic          rd_acc;
  logic [1:0]    line_lvl;
  logic          both_low;
  logic          kstate;
  logic          disc_evt;
  logic          conn_evt;
  logic          resume_evt;
  logic [HN-1:0] host_hw_set;
  logic [HN-1:0] host_masked;
  logic [EN-1:0] ep_flag;
  logic [EN-1:0] ep_masked;
  logic [1:0]    ep_done;
  logic [BW-1:0] ep_rem   [NEP];
  logic [1:0]    ep_blk_load;
  logic [1:0]    ep_flag_set;
  logic [1:0]    ep_flag_clr;
  logic [1:0]    ep_word_acc;
  logic [1:0]    ep_byte_acc;
  logic [HN-1:0] hc_hi;
  logic [HN-1:0] hc_med;
  logic [HN-1:0] hc_lo;
  logic [EN-1:0] ec_hi;
  logic [EN-1:0] ec_med;
  logic [EN-1:0] ec_lo;
  logic          ep_hit;
  logic          ep_sel;
  logic [4:0]    ep_ofs;

  // apb phases; the slave never waits
  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite & hit;
  assign rd_acc  = psel & penable & ~pwrite & hit;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign ep_hit  = (paddr[11:6] == usbh_pkg::EP_REGION);
  assign ep_sel  = paddr[5];
  assign ep_ofs  = paddr[4:0];

  // line sampling and the detach/attach filter
  pin_sync #(.W(2)) u_line_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   ({dp_in, dm_in}),
    .level (line_lvl)
  );
  assign both_low = ~line_lvl[1] & ~line_lvl[0];
  // k-state: dm high for full speed, dp high for low speed
  assign kstate   = (line_lvl[1] ^ line_lvl[0]) & (line_lvl[0] ^ low_speed);

  // one counter times whichever line condition would change the connection state
  always_ff @(posedge clk) begin
    if (rst || bus_reset_active || (both_low != conn_reg)) begin
      line_cnt_reg <= '0;
    end else if (line_cnt_reg != CW'(DISC_CYCLES - 1)) begin
      line_cnt_reg <= line_cnt_reg + CW'(1);
    end
  end
  assign disc_evt = conn_reg & both_low & ~bus_reset_active & (line_cnt_reg == CW'(DISC_CYCLES - 1));
  assign conn_evt = ~conn_reg & ~both_low & ~bus_reset_active & (line_cnt_reg == CW'(DISC_CYCLES - 1));

  // connection state; bus reset drops it without a flag
  always_ff @(posedge clk) begin
    if (rst || bus_reset_active) begin
      conn_reg <= 1'b0;
    end else if (disc_evt) begin
      conn_reg <= 1'b0;
    end else if (conn_evt) begin
      conn_reg <= 1'b1;
    end
  end

  // suspend state machine
  assign resume_evt = (state_reg == usbh_pkg::BUS_SUSPEND) &
                      (~suspend_request_req_reg | kstate | disc_evt | conn_evt);
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= usbh_pkg::BUS_ACTIVE;
    end else begin
      case (state_reg)
        usbh_pkg::BUS_ACTIVE: begin
          if (suspend_request_req_reg) state_reg <= usbh_pkg::BUS_SUSPEND;
        end
        usbh_pkg::BUS_SUSPEND: begin
          if (resume_evt) state_reg <= usbh_pkg::BUS_RESUME;
        end
        usbh_pkg::BUS_RESUME: begin
          state_reg <= usbh_pkg::BUS_ACTIVE;
        end
        default: begin
          state_reg <= usbh_pkg::BUS_ACTIVE;
        end
      endcase
    end
  end

  // suspend request; resume drops it so the bus does not fall straight back
  always_ff @(posedge clk) begin
    if (rst || resume_evt) begin
      suspend_request_req_reg <= 1'b0;
    end else if (wr_acc && paddr == usbh_pkg::HOST_STATUS_OFS) begin
      suspend_request_req_reg <= pwdata[usbh_pkg::ST_SUSPEND_BIT];
    end
  end

  // bus drive is floated and unneeded clocks gated while suspended
  always_ff @(posedge clk) begin
    if (rst) begin
      dp_out     <= 1'b0;
      dm_out     <= 1'b0;
      usb_oe     <= 1'b0;
      clk_run_en <= 1'b1;
    end else begin
      dp_out     <= tx_dp;
      dm_out     <= tx_dm;
      usb_oe     <= tx_oe & (state_reg != usbh_pkg::BUS_SUSPEND);
      clk_run_en <= (state_reg != usbh_pkg::BUS_SUSPEND);
    end
  end

  // host flags: hardware and set-register writes win over write-one clears
  assign host_hw_set[usbh_pkg::FLG_DISC_BIT]   = disc_evt;
  assign host_hw_set[usbh_pkg::FLG_RESUME_BIT] = resume_evt;
  assign host_hw_set[usbh_pkg::FLG_CONN_BIT]   = conn_evt;
  always_ff @(posedge clk) begin
    if (rst) begin
      host_flag_reg <= '0;
    end else begin
      host_flag_reg <= (host_flag_reg & ~((wr_acc && paddr == usbh_pkg::HOST_INTR_OFS) ? pwdata[HN-1:0] : '0))
                     | host_hw_set
                     | ((wr_acc && paddr == usbh_pkg::HOST_SET_OFS) ? pwdata[HN-1:0] : '0);
    end
  end

  // software configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      host_mask_reg <= '0;
      ep_mask_reg   <= '0;
      lvl1_reg      <= '0;
      lvl2_reg      <= '0;
      drq_en_reg    <= '0;
    end else if (wr_acc) begin
      if (paddr == usbh_pkg::HOST_MASK_OFS) host_mask_reg <= pwdata[HN-1:0];
      if (paddr == usbh_pkg::EP_MASK_OFS)   ep_mask_reg   <= pwdata[EN-1:0];
      if (paddr == usbh_pkg::LVL1_SEL_OFS)  lvl1_reg      <= pwdata[2*HN-1:0];
      if (paddr == usbh_pkg::LVL2_SEL_OFS)  lvl2_reg      <= pwdata[2*EN-1:0];
      if (paddr == usbh_pkg::DMA_ENBL_OFS)  drq_en_reg    <= pwdata[1:0];
    end
  end

  // endpoint register strobes
  always_comb begin
    for (int n = 0; n < NEP; n++) begin
      ep_blk_load[n] = wr_acc & ep_hit & (ep_sel == n[0]) & (ep_ofs == usbh_pkg::EP_BLK_OFS);
      ep_word_acc[n] = psel & penable & ep_hit & (ep_sel == n[0]) & (ep_ofs == usbh_pkg::EP_WORD_OFS);
      ep_byte_acc[n] = psel & penable & ep_hit & (ep_sel == n[0]) & (ep_ofs == usbh_pkg::EP_BYTE_OFS);
      ep_flag_set[n] = pkt_done[n] | (wr_acc & (paddr == usbh_pkg::EP_SET_OFS) & pwdata[n]);
      ep_flag_clr[n] = wr_acc & (paddr == usbh_pkg::EP_INTR_OFS) & pwdata[n];
    end
  end

  // endpoint control and block registers
  always_ff @(posedge clk) begin
    if (rst) begin
      auto_reg <= '0;
      for (int n = 0; n < NEP; n++) begin
        pks_reg[n] <= usbh_pkg::PKS_RESET;
        blk_reg[n] <= usbh_pkg::BLK_RESET;
      end
    end else begin
      for (int n = 0; n < NEP; n++) begin
        if (wr_acc && ep_hit && ep_sel == n[0] && ep_ofs == usbh_pkg::EP_CTL_OFS) begin
          pks_reg[n]  <= pwdata[PW-1:0];
          auto_reg[n] <= pwdata[usbh_pkg::CTL_AUTO_BIT];
        end
        if (ep_blk_load[n]) blk_reg[n] <= pwdata[BW-1:0];
      end
    end
  end

  // per-endpoint automatic request engines
  for (genvar g = 0; g < NEP; g++) begin : g_ep
    ep_dma_engine #(.PKS_W(PW), .BLK_W(BW)) u_eng (
      .clk         (clk),
      .rst         (rst),
      .auto_en     (auto_reg[g]),
      .req_en      (drq_en_reg[g]),
      .pkt_size    (pks_reg[g]),
      .blk_count   (pwdata[BW-1:0]),
      .blk_load    (ep_blk_load[g]),
      .flag_set    (ep_flag_set[g]),
      .flag_clear  (ep_flag_clr[g]),
      .word_access (ep_word_acc[g]),
      .flag        (ep_flag[g]),
      .dma_req     (dma_req[g]),
      .done        (ep_done[g]),
      .remaining   (ep_rem[g])
    );
  end

  // endpoint buffer strobes, one cycle after the data port access
  always_ff @(posedge clk) begin
    if (rst) begin
      buf_wr       <= '0;
      buf_rd       <= '0;
      buf_two_byte <= 1'b0;
      buf_wdata    <= '0;
    end else begin
      buf_wr       <= (ep_word_acc | ep_byte_acc) & {2{pwrite}};
      buf_rd       <= (ep_word_acc | ep_byte_acc) & {2{~pwrite}};
      buf_two_byte <= |ep_word_acc;
      buf_wdata    <= (|ep_byte_acc) ? {8'h00, pwdata[7:0]} : pwdata[15:0];
    end
  end

  // masked status and per-level causes
  assign host_masked = host_flag_reg & host_mask_reg;
  assign ep_masked   = ep_flag & ep_mask_reg;
  always_comb begin
    for (int i = 0; i < HN; i++) begin
      hc_hi[i]  = host_masked[i] & (lvl1_reg[2*i +: 2] == usbh_pkg::LVL_HI);
      hc_med[i] = host_masked[i] & (lvl1_reg[2*i +: 2] == usbh_pkg::LVL_MED);
      hc_lo[i]  = host_masked[i] & ~hc_hi[i] & ~hc_med[i];
    end
    for (int i = 0; i < EN; i++) begin
      ec_hi[i]  = ep_masked[i] & (lvl2_reg[2*i +: 2] == usbh_pkg::LVL_HI);
      ec_med[i] = ep_masked[i] & (lvl2_reg[2*i +: 2] == usbh_pkg::LVL_MED);
      ec_lo[i]  = ep_masked[i] & ~ec_hi[i] & ~ec_med[i];
    end
  end

  // interrupt lines, registered to keep them glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_hi  <= 1'b0;
      irq_med <= 1'b0;
      irq_lo  <= 1'b0;
    end else begin
      irq_hi  <= |{hc_hi, ec_hi};
      irq_med <= |{hc_med, ec_med};
      irq_lo  <= |{hc_lo, ec_lo};
    end
  end

  // read decode; unmapped addresses answer with pslverr
  always_comb begin
    rd_data = '0;
    hit     = 1'b1;
    if (ep_hit) begin
      case (ep_ofs)
        usbh_pkg::EP_CTL_OFS:  rd_data = {21'h0, auto_reg[ep_sel], pks_reg[ep_sel]};
        usbh_pkg::EP_STAT_OFS: rd_data = {13'h0, ep_done[ep_sel], dma_req[ep_sel], ep_flag[ep_sel], ep_rem[ep_sel]};
        usbh_pkg::EP_BYTE_OFS: rd_data = {24'h0, (ep_sel ? buf_rdata1[7:0] : buf_rdata0[7:0])};
        usbh_pkg::EP_WORD_OFS: rd_data = {16'h0, (ep_sel ? buf_rdata1 : buf_rdata0)};
        usbh_pkg::EP_BLK_OFS:  rd_data = {16'h0, blk_reg[ep_sel]};
        default:               hit     = 1'b0;
      endcase
    end else begin
      case (paddr)
        usbh_pkg::HOST_STATUS_OFS: rd_data = {29'h0, (state_reg == usbh_pkg::BUS_SUSPEND), conn_reg, suspend_request_req_reg};
        usbh_pkg::HOST_INTR_OFS:   rd_data = {29'h0, host_flag_reg};
        usbh_pkg::HOST_SET_OFS:    rd_data = {29'h0, host_flag_reg};
        usbh_pkg::HOST_MASK_OFS:   rd_data = {29'h0, host_mask_reg};
        usbh_pkg::HOST_MSKD_OFS:   rd_data = {29'h0, host_masked};
        usbh_pkg::EP_INTR_OFS:     rd_data = {30'h0, ep_flag};
        usbh_pkg::EP_SET_OFS:      rd_data = {30'h0, ep_flag};
        usbh_pkg::EP_MASK_OFS:     rd_data = {30'h0, ep_mask_reg};
        usbh_pkg::EP_MSKD_OFS:     rd_data = {30'h0, ep_masked};
        usbh_pkg::LVL1_SEL_OFS:    rd_data = {26'h0, lvl1_reg};
        usbh_pkg::LVL2_SEL_OFS:    rd_data = {28'h0, lvl2_reg};
        usbh_pkg::HOST_CAUSE_HI:   rd_data = {29'h0, hc_hi};
        usbh_pkg::HOST_CAUSE_MED:  rd_data = {29'h0, hc_med};
        usbh_pkg::HOST_CAUSE_LO:   rd_data = {29'h0, hc_lo};
        usbh_pkg::EP_CAUSE_HI:     rd_data = {30'h0, ec_hi};
        usbh_pkg::EP_CAUSE_MED:    rd_data = {30'h0, ec_med};
        usbh_pkg::EP_CAUSE_LO:     rd_data = {30'h0, ec_lo};
        usbh_pkg::DMA_ENBL_OFS:    rd_data = {30'h0, drq_en_reg};
        default:                   hit     = 1'b0;
      endcase
    end
  end

  // read data captured in the setup cycle, shown in the access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_data;
    end
  end

endmodule
`default_nettype wire

/* core/usbh_pkg.sv */
// constants shared by the usb host auto-dma, suspend and detach logic
// assumes a 125 mhz peripheral clock and an apb register bus with 32-bit data
package usbh_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int DISC_TIME_NS  = 2500;   // both lines low this long means detach
  localparam int DISC_CYCLES   = (DISC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISC_CNT_W    = 9;

  // endpoints and field widths
  localparam int NUM_EP     = 2;
  localparam int PKS_W      = 10;
  localparam int BLK_W      = 16;
  localparam int HOST_SRC_N = 3;
  localparam int EP_SRC_N   = 2;

  // register byte addresses
  localparam logic [11:0] HOST_STATUS_OFS = 12'h000;
  localparam logic [11:0] HOST_INTR_OFS   = 12'h004;
  localparam logic [11:0] HOST_SET_OFS    = 12'h008;
  localparam logic [11:0] HOST_MASK_OFS   = 12'h00C;
  localparam logic [11:0] HOST_MSKD_OFS   = 12'h010;
  localparam logic [11:0] EP_INTR_OFS     = 12'h014;
  localparam logic [11:0] EP_SET_OFS      = 12'h018;
  localparam logic [11:0] EP_MASK_OFS     = 12'h01C;
  localparam logic [11:0] EP_MSKD_OFS     = 12'h020;
  localparam logic [11:0] LVL1_SEL_OFS    = 12'h024;
  localparam logic [11:0] LVL2_SEL_OFS    = 12'h028;
  localparam logic [11:0] HOST_CAUSE_HI   = 12'h02C;
  localparam logic [11:0] HOST_CAUSE_MED  = 12'h030;
  localparam logic [11:0] HOST_CAUSE_LO   = 12'h034;
  localparam logic [11:0] EP_CAUSE_HI     = 12'h038;
  localparam logic [11:0] EP_CAUSE_MED    = 12'h03C;
  localparam logic [11:0] EP_CAUSE_LO     = 12'h040;
  localparam logic [11:0] DMA_ENBL_OFS    = 12'h044;

  // endpoint windows: base 0x080 for endpoint 1, 0x0A0 for endpoint 2
  localparam logic [5:0] EP_REGION   = 6'h02;   // paddr[11:6]
  localparam logic [4:0] EP_CTL_OFS  = 5'h00;
  localparam logic [4:0] EP_STAT_OFS = 5'h04;
  localparam logic [4:0] EP_BYTE_OFS = 5'h08;
  localparam logic [4:0] EP_WORD_OFS = 5'h0C;
  localparam logic [4:0] EP_BLK_OFS  = 5'h10;

  // field positions
  localparam int ST_SUSPEND_BIT = 0;
  localparam int ST_CONN_BIT    = 1;
  localparam int ST_SUSPENDED   = 2;
  localparam int FLG_DISC_BIT   = 0;
  localparam int FLG_RESUME_BIT = 1;
  localparam int FLG_CONN_BIT   = 2;
  localparam int CTL_AUTO_BIT   = 10;
  localparam int STAT_FLAG_BIT  = 16;
  localparam int STAT_REQ_BIT   = 17;
  localparam int STAT_DONE_BIT  = 18;

  // interrupt level codes, two bits per source
  localparam logic [1:0] LVL_LO  = 2'h0;
  localparam logic [1:0] LVL_MED = 2'h1;
  localparam logic [1:0] LVL_HI  = 2'h2;

  // reset values
  localparam logic [PKS_W-1:0] PKS_RESET = 10'h040;
  localparam logic [BLK_W-1:0] BLK_RESET = 16'h0000;

  typedef enum logic [1:0] {
    BUS_ACTIVE  = 2'b00,
    BUS_SUSPEND = 2'b01,
    BUS_RESUME  = 2'b10
  } bus_state_e;

endpackage

/* tb/testbench.sv */
// self-checking bench for usb_host_autodma_top
// apb master, device model; detach time cut to 8 cycles
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_oe = 1'b0;
  logic        bus_reset_active = 1'b0, pready, pslverr, dp, dm, usb_oe, clk_run_en, irq_lo, dp_out, dm_out;
  logic        tx_dp = 1'b0, tx_dm = 1'b0;
  logic [15:0] buf_wdata;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0]  pkt_done = 2'h0, mode = 2'h1, dma_req;
  int          err_count = 0, samples_checked = 0;
  always #4 clk = ~clk;
  usb_dev_model dev (.mode(mode), .dp(dp), .dm(dm));
  usb_host_autodma_top #(.DISC_CYCLES(8)) uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dp_in(dp), .dm_in(dm), .low_speed(1'b0), .tx_dp(tx_dp), .tx_dm(tx_dm), .tx_oe(tx_oe), .dp_out(dp_out),
    .dm_out(dm_out), .usb_oe(usb_oe), .clk_run_en(clk_run_en), .bus_reset_active(bus_reset_active),
    .pkt_done(pkt_done), .dma_req(dma_req), .buf_wr(), .buf_rd(), .buf_two_byte(), .buf_wdata(buf_wdata),
    .buf_rdata0(16'h1234), .buf_rdata1(16'h5678), .irq_hi(), .irq_med(), .irq_lo(irq_lo));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer; idle edge first so strobes never double up
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic pulse();
    @(posedge clk);
    pkt_done <= 2'h1;
    @(posedge clk);
    pkt_done <= 2'h0;
    @(negedge clk);
  endtask
  task automatic t_detach();
    // let the idle lines pass the sync and attach timer first
    repeat (20) @(posedge clk);
    apb(1'b1, 12'h00C, 32'h1);
    rchk(12'h080, 32'h3FF, 32'h040);
    rchk(12'h000, 32'h2, 32'h2);
    apb(1'b1, 12'h004, 32'h7);
    mode <= 2'h0;
    rchk(12'h004, 32'h1, 32'h0);
    repeat (15) @(posedge clk);
    rchk(12'h000, 32'h2, 32'h0);
    rchk(12'h004, 32'h1, 32'h1);
    @(negedge clk);
    chk(irq_lo, 32'h1);
    apb(1'b1, 12'h004, 32'h1);
    rchk(12'h004, 32'h1, 32'h0);
    mode <= 2'h1;
  endtask
  task automatic t_bus_reset();
    repeat (20) @(posedge clk);
    apb(1'b1, 12'h004, 32'h7);
    bus_reset_active <= 1'b1;
    rchk(12'h000, 32'h2, 32'h0);
    bus_reset_active <= 1'b0;
    rchk(12'h004, 32'h1, 32'h0);
  endtask
  // write-zero and k-state wake-ups
  task automatic t_suspend();
    for (int i = 0; i < 2; i++) begin
      repeat (20) @(posedge clk);
      apb(1'b1, 12'h004, 32'h7);
      tx_oe <= 1'b1;
      tx_dp <= 1'b1;
      apb(1'b1, 12'h000, 32'h1);
      repeat (4) @(negedge clk);
      chk(clk_run_en | usb_oe, 32'h0);
      chk({dp_out, dm_out}, 32'h2);
      rchk(12'h004, 32'h2, 32'h0);
      if (i == 0) begin
        apb(1'b1, 12'h000, 32'h0);
      end else begin
        mode <= 2'h2;
      end
      repeat (8) @(negedge clk);
      chk(clk_run_en, 32'h1);
      rchk(12'h004, 32'h2, 32'h2);
      mode <= 2'h1;
    end
  endtask
  task automatic t_auto_dma();
    apb(1'b1, 12'h080, 32'h4);
    apb(1'b1, 12'h090, 32'h8);
    apb(1'b1, 12'h044, 32'h1);
    pulse();
    chk(dma_req, 32'h0);
    rchk(12'h014, 32'h1, 32'h1);
    apb(1'b1, 12'h014, 32'h3);
    apb(1'b1, 12'h080, 32'h404);
    for (int p = 0; p < 3; p++) begin
      pulse();
      chk(dma_req, (p < 2) ? 32'h1 : 32'h0);
      apb(1'b0, 12'h08C, 32'h0);
      apb(1'b0, 12'h0AC, 32'h0);
      apb(1'b0, 12'h08C, 32'h0);
      @(negedge clk);
      chk(dma_req, 32'h0);
    end
    rchk(12'h084, 32'h50000, 32'h40000);
    // odd tail by software: byte port moves must not count toward the packet
    pulse();
    apb(1'b1, 12'h088, 32'hA5);
    @(negedge clk);
    chk(buf_wdata, 32'hA5);
    rchk(12'h088, 32'hFF, 32'h34);
    apb(1'b0, 12'h08C, 32'h0);
    rchk(12'h084, 32'h10000, 32'h10000);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_detach();
    t_bus_reset();
    t_suspend();
    t_auto_dma();
    end_of_test();
  end
  // hang guard, far beyond the expected run
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire

/* tb/usb_dev_model.sv */
// full-speed device model: line levels seen by the host
// host pull-downs take released lines low
`timescale 1ns/10ps
`default_nettype none
module usb_dev_model (
  input  wire logic [1:0] mode,
  output logic            dp,
  output logic            dm
);
  // mode 0 detached, 1 idle, 2 resume signalling
  always_comb begin
    dp = (mode == 2'h1); // detached lines fall low
    dm = (mode == 2'h2); // k-state drives the minus line
  end
endmodule
`default_nettype wire

/* tb/usbh_props.sv */
// port checker for usb_host_autodma_top
// bound below; one clock domain, sync reset
`timescale 1ns/10ps
`default_nettype none
module usbh_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        tx_oe,
  input wire logic        usb_oe,
  input wire logic        clk_run_en,
  input wire logic [1:0]  dma_req,
  input wire logic [1:0]  buf_wr,
  input wire logic [1:0]  buf_rd
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // access phase of an apb transfer
  wire acc = psel && penable;
  a_slverr_access: assert property (pslverr |-> acc) else $error("stray slave error");
  a_oe_gate: assert property (!$past(rst) |-> usb_oe == ($past(tx_oe) && clk_run_en))
    else $error("bus drive not floated in suspend");
  a_buf_write: assert property (acc && pwrite && paddr[11:3] == 9'h011 |=> buf_wr[0])
    else $error("no buffer write strobe");
  a_buf_read: assert property (acc && !pwrite && paddr[11:3] == 9'h015 |=> buf_rd[1])
    else $error("no buffer read strobe");
  a_strobe_single: assert property (buf_wr != 2'h0 |=> buf_wr == 2'h0) else $error("long strobe");
  a_dma_reset: assert property ($past(rst) |-> dma_req == 2'h0) else $error("request after reset");
  a_suspend_entry: assert property (acc && pwrite && paddr == 12'h000 && pwdata[0] |-> ##[2:4] !clk_run_en)
    else $error("suspend not entered");
  a_suspend_float: assert property ($fell(clk_run_en) |-> !usb_oe) else $error("bus driven in suspend");
  c_dma: cover property (dma_req[0]);
  c_suspend_request: cover property (!clk_run_en);
  c_rd: cover property (buf_rd[1]);
endmodule
bind usb_host_autodma_top usbh_props u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .tx_oe(tx_oe), .usb_oe(usb_oe),
  .clk_run_en(clk_run_en), .dma_req(dma_req), .buf_wr(buf_wr), .buf_rd(buf_rd));
`default_nettype wire
